// ===== hdl/adcsp_top.v
// serial control port of the delta-sigma converter: command decode,
// data shifting, configuration/offset/gain registers, reset and power modes
// assumes: serial pins and crystal pin are asynchronous to clock;
// conversion words arrive from same-clock logic with a one-cycle strobe
`timescale 1ns/10ps
`include "adcsp_defs.vh"

module adcsp_top (
   // system
   input  wire        clock,
   input  wire        rst_b,
   input  wire        clk_en,
   // serial link
   input  wire        cs_b,
   input  wire        sclk,
   input  wire        sdi,
   output reg         sdo,
   output wire        sdo_oe_b,
   // oscillator
   input  wire        crystal_clock_input,
   output wire        osc_enable,
   // conversion engine
   input  wire [23:0] conv_data,
   input  wire        conv_data_valid,
   output reg         conv_start,
   output wire        conv_continuous,
   output wire        filter_run,
   output wire [23:0] offset_value,
   output wire [23:0] gain_value,
   output wire [2:0]  word_rate_field,
   // power and reset status
   output wire        low_power_mode,
   output wire        standby_mode,
   output wire        sleep_mode,
   output wire        system_reset,
   // latch pins
   output wire [3:0]  digital_latch_outputs,
   output wire [1:0]  analog_switch_outputs
);

   localparam ST_CMD  = 1'b0;
   localparam ST_DATA = 1'b1;

   // synchronisers: bit0 chip select, bit1 serial clock, bit2 data in, bit3 crystal
   reg  [3:0]  s1_r;
   reg  [3:0]  s2_r;
   reg  [1:0]  s3_r;

   reg         mode_r;
   reg  [6:0]  cnt_r;
   reg  [6:0]  len_r;
   reg  [2:0]  sel_r;
   reg         rd_r;
   reg  [6:0]  cmd_sh_r;
   reg  [71:0] sh_r;
   reg  [6:0]  ones_r;
   reg  [23:0] cfg_r;
   reg  [23:0] off_r;
   reg  [23:0] gain_r;
   reg  [23:0] conv_r;
   reg         ready_r;
   reg         cont_r;
   reg         psave_r;
   reg         pu_busy_r;
   reg  [9:0]  pu_cnt_r;

   wire        cs_act = ~s2_r[0];
   wire        rise   = cs_act & s2_r[1] & ~s3_r[0];
   wire        fall   = cs_act & ~s2_r[1] & s3_r[0];
   wire        sdi_s  = s2_r[2];
   wire        xedge  = s2_r[3] & ~s3_r[1];
   wire [7:0]  cmd    = {cmd_sh_r, sdi_s};
   wire [71:0] sh_in  = {sh_r[70:0], sdi_s};
   wire        resync = rise & ~sdi_s & (ones_r == `ADCSP_SYNC_ONES);
   wire        byte_done = rise & (mode_r == ST_CMD) & (cnt_r == 7'h07);
   wire        data_done = rise & (mode_r == ST_DATA) & (cnt_r == len_r);

   // data-phase length minus one for a command; zero means no data phase
   function [6:0] adcsp_len;
      input [7:0] c;
      input       pf;
      begin
         adcsp_len = 7'h00;
         if (c == `ADCSP_CMD_NULL) begin
            if (pf)
               adcsp_len = `ADCSP_LEN_WORD;
         end else if (c[`ADCSP_CMD_EXEC] & ~c[`ADCSP_CMD_SINGLE] & ~c[`ADCSP_CMD_CONT]
                      & ~c[`ADCSP_CMD_PSAVE]) begin
            if (c[`ADCSP_CMD_SEL_HI:`ADCSP_CMD_SEL_LO] == `ADCSP_SEL_SETUP)
               adcsp_len = `ADCSP_LEN_SETUP;
            else if (~c[`ADCSP_CMD_SEL_HI])
               adcsp_len = `ADCSP_LEN_WORD;
         end
      end
   endfunction

   wire [2:0]  cmd_sel   = cmd[`ADCSP_CMD_SEL_HI:`ADCSP_CMD_SEL_LO];
   // reserved selects kill the whole command, including its action bits
   wire        cmd_valid = cmd[`ADCSP_CMD_EXEC] & (cmd_sel <= `ADCSP_SEL_SETUP);
   wire [6:0]  cmd_len   = adcsp_len(cmd, cfg_r[`ADCSP_CFG_PF]);

   always @(posedge clock) begin
      if (!rst_b) begin
         s1_r <= 4'h1;
         s2_r <= 4'h1;
         s3_r <= 2'h0;
      end else if (clk_en) begin
         s1_r <= {crystal_clock_input, sdi, sclk, cs_b};
         s2_r <= s1_r;
         s3_r <= {s2_r[3], s2_r[1]};
      end
   end

   // power-up timeout counted on crystal edges; the port is held meanwhile
   always @(posedge clock) begin
      if (!rst_b) begin
         pu_busy_r <= 1'b1;
         pu_cnt_r  <= 10'h000;
      end else if (clk_en) begin
         if (pu_busy_r && xedge) begin
            if (pu_cnt_r == `ADCSP_PU_CYCLES - 10'h001)
               pu_busy_r <= 1'b0;
            pu_cnt_r <= pu_cnt_r + 10'h001;
         end
      end
   end

   // serial port state, registers and modes
   always @(posedge clock) begin
      if (!rst_b || pu_busy_r) begin
         mode_r     <= ST_CMD;
         cnt_r      <= 7'h00;
         len_r      <= 7'h00;
         sel_r      <= 3'h0;
         rd_r       <= 1'b0;
         cmd_sh_r   <= 7'h00;
         sh_r       <= 72'h0;
         ones_r     <= 7'h00;
         cfg_r      <= `ADCSP_CFG_RESET;
         off_r      <= `ADCSP_OFF_RESET;
         gain_r     <= `ADCSP_GAIN_RESET;
         conv_r     <= 24'h00_0000;
         ready_r    <= 1'b0;
         cont_r     <= 1'b0;
         psave_r    <= 1'b0;
         conv_start <= 1'b0;
      end else if (clk_en) begin
         conv_start <= 1'b0;
         if (rise) begin
            if (sdi_s)
               ones_r <= (ones_r == `ADCSP_SYNC_ONES) ? ones_r : ones_r + 7'h01;
            else
               ones_r <= 7'h00;
         end
         if (resync) begin
            // only the port state returns; registers are left alone
            mode_r <= ST_CMD;
            cnt_r  <= 7'h00;
         end else if (rise && mode_r == ST_CMD) begin
            cmd_sh_r <= cmd[6:0];
            cnt_r    <= cnt_r + 7'h01;
            if (byte_done) begin
               cnt_r <= 7'h00;
               if (cmd == `ADCSP_CMD_NULL) begin
                  ready_r <= 1'b0;
                  if (cmd_len != 7'h00) begin
                     mode_r <= ST_DATA;
                     len_r  <= cmd_len;
                     sel_r  <= `ADCSP_SEL_DATA;
                     rd_r   <= 1'b1;
                     sh_r   <= {conv_r, 48'h0};
                  end
               end else if (cmd_valid) begin
                  psave_r <= cmd[`ADCSP_CMD_PSAVE];
                  if (cmd[`ADCSP_CMD_SINGLE] && !cfg_r[`ADCSP_CFG_RS])
                     conv_start <= 1'b1;
                  if (cmd[`ADCSP_CMD_SINGLE] || cmd[`ADCSP_CMD_CONT])
                     cont_r <= cmd[`ADCSP_CMD_CONT];
                  if (cmd_len != 7'h00) begin
                     mode_r <= ST_DATA;
                     len_r  <= cmd_len;
                     sel_r  <= cmd_sel;
                     rd_r   <= cmd[`ADCSP_CMD_READ];
                     if (cmd[`ADCSP_CMD_READ]) begin
                        if (cmd_sel == `ADCSP_SEL_OFFSET)
                           sh_r <= {off_r, 48'h0};
                        else if (cmd_sel == `ADCSP_SEL_GAIN)
                           sh_r <= {gain_r, 48'h0};
                        else if (cmd_sel == `ADCSP_SEL_CONFIG)
                           sh_r <= {cfg_r, 48'h0};
                        else if (cmd_sel == `ADCSP_SEL_DATA)
                           sh_r <= {conv_r, 48'h0};
                        else
                           sh_r <= {off_r, gain_r, cfg_r};
                        // reading configuration is what releases the flag
                        if (cmd_sel == `ADCSP_SEL_CONFIG || cmd_sel == `ADCSP_SEL_SETUP)
                           cfg_r[`ADCSP_CFG_RV] <= 1'b0;
                        if (cmd_sel == `ADCSP_SEL_DATA)
                           ready_r <= 1'b0;
                     end
                  end
               end
            end
         end else if (rise && mode_r == ST_DATA) begin
            sh_r  <= sh_in;
            cnt_r <= cnt_r + 7'h01;
            if (data_done) begin
               mode_r <= ST_CMD;
               cnt_r  <= 7'h00;
               if (!rd_r) begin
                  if (sel_r == `ADCSP_SEL_OFFSET)
                     off_r <= sh_in[23:0];
                  else if (sel_r == `ADCSP_SEL_GAIN)
                     gain_r <= sh_in[23:0];
                  else if (sel_r == `ADCSP_SEL_SETUP) begin
                     off_r  <= sh_in[71:48];
                     gain_r <= sh_in[47:24];
                  end
                  if (sel_r == `ADCSP_SEL_CONFIG || sel_r == `ADCSP_SEL_SETUP) begin
                     if (sh_in[`ADCSP_CFG_RS]) begin
                        // system reset: defaults, flag set, held until the bit is cleared
                        cfg_r   <= `ADCSP_CFG_RESET | (24'h00_0001 << `ADCSP_CFG_RS);
                        off_r   <= `ADCSP_OFF_RESET;
                        gain_r  <= `ADCSP_GAIN_RESET;
                        ready_r <= 1'b0;
                        cont_r  <= 1'b0;
                        psave_r <= 1'b0;
                     end else begin
                        cfg_r <= sh_in[23:0];
                        cfg_r[`ADCSP_CFG_RV] <= cfg_r[`ADCSP_CFG_RV];
                     end
                  end
               end
            end
         end
         // a fresh word beats a clear in the same cycle
         if (conv_data_valid && !cfg_r[`ADCSP_CFG_RS] && !psave_r) begin
            conv_r  <= conv_data;
            ready_r <= 1'b1;
         end
      end
   end

   // data out changes on falling serial clock so the host samples on rising
   always @(posedge clock) begin
      if (!rst_b || pu_busy_r) begin
         sdo <= 1'b1;
      end else if (clk_en) begin
         if (fall) begin
            if (mode_r == ST_DATA && rd_r)
               sdo <= sh_r[71];
            else
               sdo <= ~(cfg_r[`ADCSP_CFG_PF] & ready_r);
         end
      end
   end

   // chip select tied low simply leaves the driver on for three-wire use
   assign sdo_oe_b = s2_r[0] | pu_busy_r;

   assign digital_latch_outputs = cfg_r[`ADCSP_CFG_DIG_HI:`ADCSP_CFG_DIG_LO];
   assign analog_switch_outputs = cfg_r[`ADCSP_CFG_ANALOG_HI:`ADCSP_CFG_ANALOG_LO];
   assign low_power_mode  = cfg_r[`ADCSP_CFG_LOWPWR];
   assign standby_mode    = psave_r & ~cfg_r[`ADCSP_CFG_PSSEL];
   assign sleep_mode      = psave_r & cfg_r[`ADCSP_CFG_PSSEL];
   // stopping the oscillator means the host owns the restart delay
   assign osc_enable      = ~sleep_mode;
   assign filter_run      = ~psave_r & ~system_reset;
   assign system_reset    = pu_busy_r | cfg_r[`ADCSP_CFG_RS];
   assign word_rate_field = cfg_r[`ADCSP_CFG_WR_HI:`ADCSP_CFG_WR_LO];
   assign conv_continuous = cont_r & ~cfg_r[`ADCSP_CFG_RS];
   assign offset_value    = off_r;
   assign gain_value      = gain_r;

endmodule // adcsp_top

// ===== hdl/adcsp_defs.vh
// constants for the converter serial control port
// assumes one system clock of 100 MHz; serial and crystal pins arrive asynchronously, conversion words on the same clock
`ifndef ADCSP_DEFS_VH
`define ADCSP_DEFS_VH

// configuration register layout
`define ADCSP_CFG_RESET     24'h00_0040
`define ADCSP_OFF_RESET     24'h00_0000
`define ADCSP_GAIN_RESET    24'h40_0000
`define ADCSP_CFG_ANALOG_HI 23
`define ADCSP_CFG_ANALOG_LO 22
`define ADCSP_CFG_DIG_HI    21
`define ADCSP_CFG_DIG_LO    18
`define ADCSP_CFG_LOWPWR    16
`define ADCSP_CFG_WR_HI     15
`define ADCSP_CFG_WR_LO     13
`define ADCSP_CFG_RS        7
`define ADCSP_CFG_RV        6
`define ADCSP_CFG_PF        5
`define ADCSP_CFG_PSSEL     4

// command byte fields
`define ADCSP_CMD_EXEC      7
`define ADCSP_CMD_SINGLE    6
`define ADCSP_CMD_CONT      5
`define ADCSP_CMD_READ      4
`define ADCSP_CMD_SEL_HI    3
`define ADCSP_CMD_SEL_LO    1
`define ADCSP_CMD_PSAVE     0
`define ADCSP_SEL_OFFSET    3'h0
`define ADCSP_SEL_GAIN      3'h1
`define ADCSP_SEL_CONFIG    3'h2
`define ADCSP_SEL_DATA      3'h3
`define ADCSP_SEL_SETUP     3'h4
`define ADCSP_CMD_NULL      8'h00
`define ADCSP_CMD_PSAVE_ON  8'h81

// data phase lengths in bits, minus one
`define ADCSP_LEN_WORD      7'h17
`define ADCSP_LEN_SETUP     7'h47

// resync: fill bytes are all ones, the end byte has a trailing zero
`define ADCSP_SYNC_FILL_MIN 15
`define ADCSP_SYNC_ONES     7'h7F

// power-up timeout in oscillator cycles
`define ADCSP_PU_CYCLES     10'h3EA

`endif

// ===== tb/adcsp_chk_sva.sv
// pin checker for the converter serial port
// assumes a bind onto adcsp_top, one clock domain
`timescale 1ns/10ps
module adcsp_chk (
   // system
   input wire        clock,
   input wire        rst_b,
   // link and oscillator
   input wire        cs_b,
   input wire        sdo_oe_b,
   input wire        crystal_clock_input,
   input wire        osc_enable,
   // status
   input wire        conv_start,
   input wire        filter_run,
   input wire [23:0] offset_value,
   input wire [2:0]  word_rate_field,
   input wire        low_power_mode,
   input wire        standby_mode,
   input wire        sleep_mode,
   input wire        system_reset,
   input wire [3:0]  digital_latch_outputs
);
   reg [2:0]  xs_r;
   reg [10:0] pu_cnt_r;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // crystal rises since reset; two short of the count to allow for sync skew
   always @(posedge clock) begin
      xs_r <= {xs_r[1:0], crystal_clock_input};
      if (!rst_b)
         pu_cnt_r <= 11'h000;
      else if (xs_r[1] && !xs_r[2] && pu_cnt_r != 11'h7ff)
         pu_cnt_r <= pu_cnt_r + 11'h001;
   end
   property p_oe_off; cs_b [*4] |=> sdo_oe_b; endproperty
   a_oe_off: assert property (p_oe_off) else $error("sdo driven");
   property p_cs_ign; cs_b [*8] |=> $stable(offset_value); endproperty
   a_cs_ign: assert property (p_cs_ign) else $error("change while idle");
   property p_pins;
      $changed({digital_latch_outputs, word_rate_field, low_power_mode}) |-> !cs_b;
   endproperty
   a_pins: assert property (p_pins) else $error("pins moved");
   property p_rst; system_reset |-> !filter_run; endproperty
   a_rst: assert property (p_rst) else $error("filter in reset");
   property p_psave; (standby_mode || sleep_mode) |-> !filter_run && !(standby_mode && sleep_mode);
   endproperty
   a_psave: assert property (p_psave) else $error("power save");
   property p_osc; osc_enable != sleep_mode; endproperty
   a_osc: assert property (p_osc) else $error("oscillator");
   property p_start; conv_start |-> !cs_b ##1 !conv_start; endproperty
   a_start: assert property (p_start) else $error("start pulse");
   property p_pu; $fell(system_reset) |-> pu_cnt_r >= 11'h3e8; endproperty
   a_pu: assert property (p_pu) else $error("power-up short");
   c_start: cover property (conv_start);
   c_sleep: cover property (sleep_mode);
   c_pu: cover property ($fell(system_reset));
endmodule // adcsp_chk

// ===== tb/adcsp_host.sv
// host model of the serial control link, sclk idles low
// assumes the system clock paces it: 4 clocks each half of sclk
`timescale 1ns/10ps
module adcsp_host (
   // timing
   input wire clock,
   // link
   output reg  cs_b,
   output reg  sclk,
   output reg  sdi,
   input  wire sdo,
   input  wire sdo_oe_b
);
   wire sdo_line = sdo_oe_b ? 1'bz : sdo;
   initial begin
      cs_b = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   task half;
      begin
         repeat (4) @(posedge clock);
         #1;
      end
   endtask
   // nb bits msb first from sh; rd keeps the last 72 bits sampled on rises
   task shift(input [79:0] sh, input integer nb, input keep, output [71:0] rd);
      integer i;
      begin
         cs_b = 1'b0;
         half;
         for (i = 0; i < nb; i = i + 1) begin
            sdi = sh[79];
            sh = sh << 1;
            half;
            rd = {rd[70:0], sdo_line};
            sclk = 1'b1;
            half;
            sclk = 1'b0;
         end
         half;
         cs_b = ~keep;
         // a released data line never holds its last bit
         sdi = ~sdi;
         // let chip select stand high before the next transfer can lower it
         if (!keep)
            half;
      end
   endtask
   task stray;
      repeat (16) begin
         sdi = ~sdi;
         half;
         sclk = 1'b1;
         half;
         sclk = 1'b0;
      end
   endtask
endmodule // adcsp_host

// ===== tb/tb.sv
// top testbench for the converter serial control port
// assumes adcsp_top, the host model and the checker are compiled
`timescale 1ns/10ps
module tb;
   reg         clock = 1'b0;
   reg         rst_b = 1'b0;
   reg         xtal = 1'b0;
   reg  [23:0] conv_data = 24'h00_0000;
   reg         conv_data_valid = 1'b0;
   wire        cs_b, sclk, sdi, sdo, sdo_oe_b, osc_enable, conv_start, conv_continuous;
   wire        filter_run, low_power_mode, standby_mode, sleep_mode, system_reset;
   wire [23:0] offset_value, gain_value;
   wire [2:0]  word_rate_field;
   wire [3:0]  digital_latch_outputs;
   wire [1:0]  analog_switch_outputs;
   integer     error_cnt = 0;
   integer     n_tests = 0;
   integer     seed = 84;
   integer     starts = 0;
   integer     k;
   reg  [71:0] rd, seen;
   reg  [71:0] exp_q[$];
   string      nm_q[$];
   reg  [23:0] c, v, w;
   event       got;
   always #5 clock = ~clock;
   // sped-up crystal that stops while the design disables it
   always #30 if (osc_enable !== 1'b0) xtal = ~xtal;
   always @(posedge clock) if (conv_start) starts <= starts + 1;
   adcsp_top u_dut (.clock(clock), .rst_b(rst_b), .clk_en(1'b1), .cs_b(cs_b), .sclk(sclk),
      .sdi(sdi), .sdo(sdo), .sdo_oe_b(sdo_oe_b), .crystal_clock_input(xtal),
      .osc_enable(osc_enable), .conv_data(conv_data), .conv_data_valid(conv_data_valid),
      .conv_start(conv_start), .conv_continuous(conv_continuous), .filter_run(filter_run),
      .offset_value(offset_value), .gain_value(gain_value), .word_rate_field(word_rate_field),
      .low_power_mode(low_power_mode), .standby_mode(standby_mode), .sleep_mode(sleep_mode),
      .system_reset(system_reset), .digital_latch_outputs(digital_latch_outputs),
      .analog_switch_outputs(analog_switch_outputs));
   adcsp_host u_host (.clock(clock), .cs_b(cs_b), .sclk(sclk), .sdi(sdi), .sdo(sdo),
      .sdo_oe_b(sdo_oe_b));
   task finish_test;
      begin
         $display("checks %0d errors %0d", n_tests, error_cnt);
         if (error_cnt == 0 && n_tests > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task note(input string nm, input [71:0] e, input [71:0] s);
      begin
         nm_q.push_back(nm);
         exp_q.push_back(e);
         seen = s;
         -> got;
         #1;
      end
   endtask
   always @(got) begin : mon
      reg [71:0] e;
      string     nm;
      e = exp_q.pop_front();
      nm = nm_q.pop_front();
      n_tests = n_tests + 1;
      if (e !== seen) begin
         error_cnt = error_cnt + 1;
         $display("wrong value %s expected %h seen %h", nm, e, seen);
      end
   end
   task wr24(input [7:0] cmd, input [23:0] dw);
      u_host.shift({cmd, dw, 48'h0}, 32, 1'b0, rd);
   endtask
   task rd24(input [7:0] cmd, input string nm, input [23:0] e);
      begin
         u_host.shift({cmd, 72'h0}, 32, 1'b0, rd);
         note(nm, e, rd[23:0]);
      end
   endtask
   initial begin
      repeat (8) @(posedge clock);
      #1 rst_b = 1'b1;
      for (k = 0; system_reset !== 1'b0 && k < 9000; k = k + 1) @(posedge clock);
      #1 if (k == 9000) begin
         error_cnt = error_cnt + 1;
         finish_test;
      end
      note("oe", 1'b1, sdo_oe_b);
      note("offset", 24'h00_0000, offset_value);
      note("gain", 24'h40_0000, gain_value);
      note("lowpwr", 1'b0, low_power_mode);
      rd24(8'h94, "cfg", 24'h00_0040);
      rd24(8'h94, "cfg", 24'h00_0000);
      for (k = 0; k < 8; k = k + 1) begin
         c = $random(seed) & 24'hFD_0000;
         c[15:13] = k[2:0];
         wr24(8'h84, c);
         note("latch", c[23:18], {analog_switch_outputs, digital_latch_outputs});
         note("rate", c[15:13], word_rate_field);
         note("lowpwr", c[16], low_power_mode);
         rd24(8'h94, "cfg", c);
      end
      v = $random(seed);
      w = $random(seed);
      u_host.shift({8'h88, w, v, c}, 80, 1'b0, rd);
      rd24(8'h90, "offset", w);
      wr24(8'h80, v);
      wr24(8'h82, w);
      note("gain_pin", w, gain_value);
      u_host.shift({8'h98, 72'h0}, 80, 1'b0, rd);
      note("setup", {v, w, c}, rd);
      u_host.shift({8'hAA, 72'h0}, 8, 1'b1, rd);
      rd24(8'h90, "offset", v);
      u_host.stray;
      rd24(8'h92, "gain", w);
      u_host.shift({3'b101, 77'h0}, 3, 1'b1, rd);
      for (k = 0; k < 16; k = k + 1)
         u_host.shift({(k == 15) ? 8'hFE : 8'hFF, 72'h0}, 8, 1'b1, rd);
      rd24(8'h90, "offset", v);
      for (k = 0; k < 2; k = k + 1) begin
         c[4] = k[0];
         wr24(8'h84, c);
         u_host.shift({8'h81, 72'h0}, 8, 1'b0, rd);
         note("standby", !k[0], standby_mode);
         note("sleep", k[0], sleep_mode);
         note("filter", 1'b0, filter_run);
         wr24(8'h80, v);
         repeat (100) @(posedge clock);
         note("filter", 1'b1, filter_run);
      end
      c[5:4] = 2'b10;
      wr24(8'h84, c);
      u_host.shift({8'hA0, 72'h0}, 8, 1'b0, rd);
      note("cont", 1'b1, conv_continuous);
      @(posedge clock) #1 conv_data = $random(seed);
      conv_data_valid = 1'b1;
      @(posedge clock) #1 conv_data_valid = 1'b0;
      rd24(8'h00, "conv", conv_data);
      u_host.shift({8'hC0, 72'h0}, 8, 1'b0, rd);
      note("starts", 1, starts);
      wr24(8'h84, 24'h00_0080);
      note("sysrst", 1'b1, system_reset);
      note("offset", 24'h00_0000, offset_value);
      wr24(8'h84, 24'h00_0000);
      note("sysrst", 1'b0, system_reset);
      rd24(8'h94, "cfg", 24'h00_0040);
      finish_test;
   end
endmodule // tb
bind adcsp_top adcsp_chk u_chk (.clock(clock), .rst_b(rst_b), .cs_b(cs_b),
   .sdo_oe_b(sdo_oe_b), .crystal_clock_input(crystal_clock_input), .osc_enable(osc_enable),
   .conv_start(conv_start), .filter_run(filter_run), .offset_value(offset_value),
   .word_rate_field(word_rate_field), .low_power_mode(low_power_mode),
   .standby_mode(standby_mode), .sleep_mode(sleep_mode), .system_reset(system_reset),
   .digital_latch_outputs(digital_latch_outputs));
